/* ppm_mux.sv */
// combinational pin mux for crystal-output pin, port 3 and port-4 pins 0..4.
// assumes control bits come registered and pin inputs are already synchronised.
module ppm_mux
(
  // control bits
  ppm_ctrl_if.mux         ctrl,
  // pins
  input  wire logic       p2_7_in,
  output logic            p2_7_out,
  output logic            p2_7_oe,
  output logic            p2_7_in_en,
  input  wire logic [7:0] p3_in,
  output logic [7:0]      p3_out,
  output logic [7:0]      p3_oe,
  output logic [7:0]      p3_in_en,
  input  wire logic [4:0] p4_in,
  output logic [4:0]      p4_out,
  output logic [4:0]      p4_oe,
  output logic [4:0]      p4_in_en,
  // port output registers and inputs seen by software
  input  wire logic [7:0] p2_out_bits,
  input  wire logic [7:0] p3_out_bits,
  input  wire logic [4:0] p4_out_bits,
  output logic            p2_7_gpio_in,
  output logic [7:0]      p3_gpio_in,
  output logic [4:0]      p4_gpio_in,
  // oscillator
  input  wire logic       crystal_osc_output,
  output logic            xtal_drv_en,
  // serial units: per pin data out, drive enable, data in
  input  wire logic [5:0] ser_out,
  input  wire logic [5:0] ser_oe,
  output logic [5:0]      ser_in,
  input  wire logic       serial_a_clock_used,
  input  wire logic       serial_b_clock_used,
  output logic            serial_b_force_3wire,
  output logic            serial_a_force_3wire,
  // second timer
  input  wire logic [2:0] timer2_compare_out,
  output logic [2:0]      capture_input_a,
  output logic [1:0]      capture_input_b,
  // analog channel enables: a5 a6 a7 a12 a13
  output logic [4:0]      analog_ch_en
);
  logic [7:0] p3_ae;
  logic [4:0] p4_ae;

  always_comb
  begin
    p3_ae = 8'h00;
    p3_ae[0] = ctrl.ae_lo[ppm_pkg::AE_LO_P30];
    p3_ae[6] = ctrl.ae_lo[ppm_pkg::AE_LO_P36];
    p3_ae[7] = ctrl.ae_lo[ppm_pkg::AE_LO_P37];
    p4_ae = 5'h00;
    p4_ae[3] = ctrl.ae_hi[ppm_pkg::AE_HI_P43];
    p4_ae[4] = ctrl.ae_hi[ppm_pkg::AE_HI_P44];
  end

  assign analog_ch_en = {p4_ae[4], p4_ae[3], p3_ae[7], p3_ae[6], p3_ae[0]};

  // crystal output: select wins over direction
  always_comb
  begin
    xtal_drv_en  = ctrl.p2_sel[ppm_pkg::XTAL_PIN];
    p2_7_out     = xtal_drv_en ? crystal_osc_output : p2_out_bits[7];
    p2_7_oe      = xtal_drv_en | ctrl.p2_dir[7];
    p2_7_in_en   = 1'b1; // input still live; a driven input draws current
    p2_7_gpio_in = p2_7_in;
  end

  // port 3: analog over select over gpio
  for (genvar g = 0; g < ppm_pkg::P3_PINS; g++)
  begin : g_p3
    always_comb
    begin
      p3_gpio_in[g] = p3_in[g] & ~p3_ae[g];
      if (p3_ae[g])
      begin
        p3_out[g]   = 1'b0;
        p3_oe[g]    = 1'b0;
        p3_in_en[g] = 1'b0;
      end
      else if (ctrl.p3_sel[g] && g <= 5)
      begin
        p3_out[g]   = ser_out[g];
        p3_oe[g]    = ser_oe[g];
        p3_in_en[g] = 1'b1;
      end
      else
      begin
        p3_out[g]   = p3_out_bits[g];
        p3_oe[g]    = ctrl.p3_dir[g];
        p3_in_en[g] = 1'b1;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < 6; i++)
      ser_in[i] = p3_in[i] & ctrl.p3_sel[i] & ~p3_ae[i];
  end

  // pin 0 clock beats b slave enable; pin 3 clock beats a slave enable
  assign serial_b_force_3wire = serial_a_clock_used;
  assign serial_a_force_3wire = serial_b_clock_used;

  // port 4 pins 0..4
  for (genvar g = 0; g < ppm_pkg::P4_PINS; g++)
  begin : g_p4
    always_comb
    begin
      p4_gpio_in[g] = p4_in[g] & ~p4_ae[g];
      if (p4_ae[g])
      begin
        p4_out[g]   = 1'b0;
        p4_oe[g]    = 1'b0;
        p4_in_en[g] = 1'b0;
      end
      else if (ctrl.p4_sel[g])
      begin
        p4_out[g]   = timer2_compare_out[g % 3];
        p4_oe[g]    = ctrl.p4_dir[g];
        p4_in_en[g] = 1'b1;
      end
      else
      begin
        p4_out[g]   = p4_out_bits[g];
        p4_oe[g]    = ctrl.p4_dir[g];
        p4_in_en[g] = 1'b1;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
      capture_input_a[i] = p4_in[i] & ctrl.p4_sel[i] & ~ctrl.p4_dir[i];
    for (int i = 0; i < 2; i++)
      capture_input_b[i] = p4_in[i+3] & ctrl.p4_sel[i+3] & ~ctrl.p4_dir[i+3] & ~p4_ae[i+3];
  end
endmodule

/* ppm_pkg.sv */
// package for the port pin function mux: control-bit positions, reset values and codes.
// assumes nothing of its surroundings beyond a single mclk domain.
package ppm_pkg;
  // control register widths and reset values
  localparam int            CTRL_W         = 8;
  localparam logic [7:0]    DIR_RST        = 8'h00;
  localparam logic [7:0]    XTAL_SEL_RST   = 8'h80;
  localparam logic [7:0]    P34SEL_RST     = 8'h00;
  localparam logic [7:0]    AE_RST         = 8'h00;
  // pin and analog-enable bit positions
  localparam int            XTAL_PIN       = 7;
  localparam int            AE_LO_P30      = 5;
  localparam int            AE_LO_P36      = 6;
  localparam int            AE_LO_P37      = 7;
  localparam int            AE_HI_P43      = 4;
  localparam int            AE_HI_P44      = 5;
  // number of port-3 and port-4 pins handled here
  localparam int            P4_PINS        = 5;
  localparam int            P3_PINS        = 8;

  // pin function chosen for reporting
  typedef enum logic [1:0]
  {
    FN_GPIO   = 2'b00,
    FN_PERIPH = 2'b01,
    FN_ANALOG = 2'b10
  } ppm_fn_t;
endpackage

/* ppm_ctrl_if.sv */
// interface carrying the registered control bits from the register stage to the mux.
// assumes both ends share mclk.
interface ppm_ctrl_if;
  logic [7:0] p2_dir;
  logic [7:0] p2_sel;
  logic [7:0] p3_dir;
  logic [7:0] p3_sel;
  logic [7:0] p4_dir;
  logic [7:0] p4_sel;
  logic [7:0] ae_lo;
  logic [7:0] ae_hi;
  modport regs (output p2_dir, p2_sel, p3_dir, p3_sel, p4_dir, p4_sel, ae_lo, ae_hi);
  modport mux  (input  p2_dir, p2_sel, p3_dir, p3_sel, p4_dir, p4_sel, ae_lo, ae_hi);
endinterface

/* ppm_regs.sv */
// control-bit register stage: direction, function-select and analog-enable bits.
// assumes write strobes are synchronous to mclk and one cycle wide per write.
module ppm_regs
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // write strobes and data
  input  wire logic [7:0] wr_en,
  input  wire logic [7:0] wr_data,
  // registered control out
  ppm_ctrl_if.regs        ctrl
);
  logic [7:0] regs_q [8];

  // reset values per register index: 0..5 ports, 6..7 analog enables
  function automatic logic [7:0] rst_val(input int idx);
    case (idx)
      1:       rst_val = ppm_pkg::XTAL_SEL_RST;
      3, 5:    rst_val = ppm_pkg::P34SEL_RST;
      6, 7:    rst_val = ppm_pkg::AE_RST;
      default: rst_val = ppm_pkg::DIR_RST;
    endcase
  endfunction

  for (genvar g = 0; g < 8; g++)
  begin : g_reg
    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
        regs_q[g] <= rst_val(g);
      else if (clk_en && wr_en[g])
        regs_q[g] <= wr_data;
    end
  end

  assign ctrl.p2_dir = regs_q[0];
  assign ctrl.p2_sel = regs_q[1];
  assign ctrl.p3_dir = regs_q[2];
  assign ctrl.p3_sel = regs_q[3];
  assign ctrl.p4_dir = regs_q[4];
  assign ctrl.p4_sel = regs_q[5];
  assign ctrl.ae_lo  = regs_q[6];
  assign ctrl.ae_hi  = regs_q[7];
endmodule

/* ppm_top.sv */
// top of the port pin function mux: control registers, pin synchronisers and the mux.
// assumes one mclk domain; pins are asynchronous and resynchronised here.
//
// How it works
// - after reset, port 3 and 4 pins are gpio with select and analog bits clear.
// - crystal pin select 1 drives oscillator output regardless of direction; reset default.
// - serial pins with select set follow the serial unit's direction, not port direction.
// - port-3 pins 1..5 map to serial b data, b clock/a enable, a transmit/receive.
// - pin 0: serial a clock beats b slave enable, forcing b into 3-wire.
// - pin 3: serial b clock beats a slave enable, forcing a into 3-wire.
// - analog-low bits select a5,a6,a7 on port-3 pins 0,6,7, disabling buffers.
// - analog-high bits 4,5 select a12,a13 on port-4 pins 3,4, disabling buffers.
// - port-3 pins 6,7 offer only gpio or analog.
// - port-4 pins 0..2 select: input feeds capture a, output gives compare.
// - port-4 pins 3,4 select: input feeds capture b, output gives compare 0,1.
module ppm_top
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // control-bit writes: 0/1 p2 dir/select, 2/3 p3 dir/select, 4/5 p4 dir/select, 6/7 ae lo/hi
  input  wire logic [7:0] wr_en,
  input  wire logic [7:0] wr_data,
  // control-bit readback
  output logic [7:0]      port2_direction_bits,
  output logic [7:0]      port2_function_select_bits,
  output logic [7:0]      port3_direction_bits,
  output logic [7:0]      port3_function_select_bits,
  output logic [7:0]      port4_direction_bits,
  output logic [7:0]      port4_function_select_bits,
  output logic [7:0]      analog_enable_low,
  output logic [7:0]      analog_enable_high,
  // pins
  input  wire logic       p2_7_i,
  output logic            p2_7_o,
  output logic            p2_7_oe,
  output logic            p2_7_ie,
  input  wire logic [7:0] p3_i,
  output logic [7:0]      p3_o,
  output logic [7:0]      p3_oe,
  output logic [7:0]      p3_ie,
  input  wire logic [4:0] p4_i,
  output logic [4:0]      p4_o,
  output logic [4:0]      p4_oe,
  output logic [4:0]      p4_ie,
  // port data registers and synchronised pin reads
  input  wire logic [7:0] p2_out_bits,
  input  wire logic [7:0] p3_out_bits,
  input  wire logic [4:0] p4_out_bits,
  output logic            p2_7_gpio_in,
  output logic [7:0]      p3_gpio_in,
  output logic [4:0]      p4_gpio_in,
  // oscillator
  input  wire logic       crystal_osc_output,
  output logic            xtal_drv_en,
  // serial units, indexed by port-3 pin 0..5
  input  wire logic [5:0] ser_out,
  input  wire logic [5:0] ser_oe,
  output logic [5:0]      ser_in,
  input  wire logic       serial_a_clock_used,
  input  wire logic       serial_b_clock_used,
  output logic            serial_b_force_3wire,
  output logic            serial_a_force_3wire,
  // second timer
  input  wire logic [2:0] timer2_compare_out,
  output logic [2:0]      capture_input_a,
  output logic [1:0]      capture_input_b,
  // converter channels a5 a6 a7 a12 a13
  output logic [4:0]      analog_ch_en
);
  ppm_ctrl_if ctrl ();

  logic [13:0] pin_s1_q;
  logic [13:0] pin_s2_q;

  // two-flop synchroniser on all pin inputs; first stage feeds only the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= 14'h0000;
      pin_s2_q <= 14'h0000;
    end
    else if (clk_en)
    begin
      pin_s1_q <= {p2_7_i, p4_i, p3_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  ppm_regs u_regs
  (
    .mclk    (mclk),
    .rst     (rst),
    .clk_en  (clk_en),
    .wr_en   (wr_en),
    .wr_data (wr_data),
    .ctrl    (ctrl)
  );

  assign port2_direction_bits       = ctrl.p2_dir;
  assign port2_function_select_bits = ctrl.p2_sel;
  assign port3_direction_bits       = ctrl.p3_dir;
  assign port3_function_select_bits = ctrl.p3_sel;
  assign port4_direction_bits       = ctrl.p4_dir;
  assign port4_function_select_bits = ctrl.p4_sel;
  assign analog_enable_low          = ctrl.ae_lo;
  assign analog_enable_high         = ctrl.ae_hi;

  // pin-facing outputs are combinational so the mux settles within the write cycle
  ppm_mux u_mux
  (
    .ctrl                 (ctrl),
    .p2_7_in              (pin_s2_q[13]),
    .p2_7_out             (p2_7_o),
    .p2_7_oe              (p2_7_oe),
    .p2_7_in_en           (p2_7_ie),
    .p3_in                (pin_s2_q[7:0]),
    .p3_out               (p3_o),
    .p3_oe                (p3_oe),
    .p3_in_en             (p3_ie),
    .p4_in                (pin_s2_q[12:8]),
    .p4_out               (p4_o),
    .p4_oe                (p4_oe),
    .p4_in_en             (p4_ie),
    .p2_out_bits          (p2_out_bits),
    .p3_out_bits          (p3_out_bits),
    .p4_out_bits          (p4_out_bits),
    .p2_7_gpio_in         (p2_7_gpio_in),
    .p3_gpio_in           (p3_gpio_in),
    .p4_gpio_in           (p4_gpio_in),
    .crystal_osc_output   (crystal_osc_output),
    .xtal_drv_en          (xtal_drv_en),
    .ser_out              (ser_out),
    .ser_oe               (ser_oe),
    .ser_in               (ser_in),
    .serial_a_clock_used  (serial_a_clock_used),
    .serial_b_clock_used  (serial_b_clock_used),
    .serial_b_force_3wire (serial_b_force_3wire),
    .serial_a_force_3wire (serial_a_force_3wire),
    .timer2_compare_out   (timer2_compare_out),
    .capture_input_a      (capture_input_a),
    .capture_input_b      (capture_input_b),
    .analog_ch_en         (analog_ch_en)
  );
endmodule

/* ppm_checker.sv */
// checker for the port pin function mux, sees only the top ports
// assumes one mclk domain; bound to ppm_top by the bench
module ppm_checker
(
  // clock, reset and writes
  input logic       mclk,
  input logic       rst,
  input logic       clk_en,
  input logic [7:0] wr_en,
  input logic [7:0] wr_data,
  // control readback
  input logic [7:0] port2_function_select_bits,
  input logic [7:0] port3_direction_bits,
  input logic [7:0] port3_function_select_bits,
  input logic [7:0] port4_direction_bits,
  input logic [7:0] port4_function_select_bits,
  input logic [7:0] analog_enable_low,
  input logic [7:0] analog_enable_high,
  // pins
  input logic       p2_7_o,
  input logic       p2_7_oe,
  input logic [7:0] p3_oe,
  input logic [7:0] p3_ie,
  input logic [4:0] p4_o,
  input logic [4:0] p4_oe,
  // peripherals
  input logic       crystal_osc_output,
  input logic       xtal_drv_en,
  input logic [5:0] ser_oe,
  input logic       serial_a_clock_used,
  input logic       serial_b_clock_used,
  input logic       serial_b_force_3wire,
  input logic       serial_a_force_3wire,
  input logic [2:0] timer2_compare_out,
  input logic [4:0] analog_ch_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> port3_function_select_bits == 8'h00 && analog_enable_low == 8'h00
    && analog_enable_high == 8'h00 && port4_function_select_bits == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("select bits not clear after reset");
  property p_xtal; port2_function_select_bits[7] |-> xtal_drv_en && p2_7_oe
    && p2_7_o == crystal_osc_output; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pin not on oscillator");
  // pin 0 is left out while analog owns it
  property p_ser; ((p3_oe[5:0] ^ ser_oe) & port3_function_select_bits[5:0]
    & ~{5'h00, analog_enable_low[5]}) == 6'h00; endproperty
  a_ser: assert property (p_ser) else $error("serial pin direction wrong");
  property p_b3w; serial_b_force_3wire == serial_a_clock_used; endproperty
  a_b3w: assert property (p_b3w) else $error("unit b 3-wire force wrong");
  property p_a3w; serial_a_force_3wire == serial_b_clock_used; endproperty
  a_a3w: assert property (p_a3w) else $error("unit a 3-wire force wrong");
  property p_alo; analog_enable_low[5] |-> !p3_oe[0] && !p3_ie[0] && analog_ch_en[0]; endproperty
  a_alo: assert property (p_alo) else $error("pin 3.0 analog not isolated");
  property p_ahi; analog_enable_high[4] |-> !p4_oe[3] && analog_ch_en[3]; endproperty
  a_ahi: assert property (p_ahi) else $error("pin 4.3 analog not isolated");
  property p_p3hi; p3_oe[7:6] == (port3_direction_bits[7:6] & ~analog_enable_low[7:6]); endproperty
  a_p3hi: assert property (p_p3hi) else $error("pins 3.6 3.7 drive wrong");
  property p_cmp0; port4_function_select_bits[0] && port4_direction_bits[0]
    |-> p4_oe[0] && p4_o[0] == timer2_compare_out[0]; endproperty
  a_cmp0: assert property (p_cmp0) else $error("pin 4.0 compare wrong");
  property p_cmp3; port4_function_select_bits[3] && port4_direction_bits[3]
    && !analog_enable_high[4] |-> p4_oe[3] && p4_o[3] == timer2_compare_out[0]; endproperty
  a_cmp3: assert property (p_cmp3) else $error("pin 4.3 compare wrong");
  property p_wr; clk_en && wr_en[5] |=> port4_function_select_bits == $past(wr_data); endproperty
  a_wr: assert property (p_wr) else $error("port 4 select write lost");
  c_ana: cover property (analog_enable_low[5] && analog_enable_high[4]);
  c_cmp: cover property (port4_function_select_bits[3] && port4_direction_bits[3]);
  c_3w: cover property (serial_a_clock_used && serial_b_clock_used);
endmodule

/* ppm_board.sv */
// board circuitry on the mux pins
// assumes the bench sets the level the board drives onto each pin
module ppm_board
(
  // device side
  input  logic       p2_7_o,
  input  logic       p2_7_oe,
  input  logic [7:0] p3_o,
  input  logic [7:0] p3_oe,
  input  logic [4:0] p4_o,
  input  logic [4:0] p4_oe,
  // board levels and pin reads
  input  logic       p2_lvl,
  input  logic [7:0] p3_lvl,
  input  logic [4:0] p4_lvl,
  output logic       p2_7_i,
  output logic [7:0] p3_i,
  output logic [4:0] p4_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // a pin the device drives reads back its own level; the board yields to it
  assign p2_7_i = p2_7_oe ? p2_7_o : p2_lvl;
  assign p3_i = (p3_oe & p3_o) | (~p3_oe & p3_lvl);
  assign p4_i = (p4_oe & p4_o) | (~p4_oe & p4_lvl);
endmodule

/* ppm_top_test.sv */
// self-checking bench for the port pin function mux
// assumes ppm_top, ppm_board and ppm_checker are compiled first
module ppm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 1'h0;
  logic       rst = 1'h1;
  logic       clk_en = 1'h1;
  logic [7:0] wr_en = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] p2_out_bits = 8'h80;
  logic [7:0] p3_out_bits = 8'h00;
  logic [4:0] p4_out_bits = 5'h00;
  logic       crystal_osc_output = 1'h1;
  logic [5:0] ser_out = 6'h00;
  logic [5:0] ser_oe = 6'h00;
  logic       serial_a_clock_used = 1'h0;
  logic       serial_b_clock_used = 1'h0;
  logic [2:0] timer2_compare_out = 3'h0;
  logic       p2_lvl = 1'h0;
  logic [7:0] p3_lvl = 8'h00;
  logic [4:0] p4_lvl = 5'h00;
  logic [7:0] port2_direction_bits, port2_function_select_bits, port3_direction_bits;
  logic [7:0] port3_function_select_bits, port4_direction_bits, port4_function_select_bits;
  logic [7:0] analog_enable_low, analog_enable_high, p3_i, p3_o, p3_oe, p3_ie, p3_gpio_in;
  logic [4:0] p4_i, p4_o, p4_oe, p4_ie, p4_gpio_in, analog_ch_en;
  logic [5:0] ser_in;
  logic [2:0] capture_input_a;
  logic [1:0] capture_input_b;
  logic       p2_7_i, p2_7_o, p2_7_oe, p2_7_ie, p2_7_gpio_in, xtal_drv_en;
  logic       serial_b_force_3wire, serial_a_force_3wire;
  int         err_count = 0;
  int         checked = 0;

  ppm_top dut (.*);
  ppm_board board (.*);

  always #4 mclk = ~mclk;

  task automatic wr(input int idx, input logic [7:0] d);
    @(posedge mclk);
    #1;
    wr_en = 8'h01 << idx;
    wr_data = d;
    @(posedge mclk);
    #1;
    wr_en = 8'h00;
  endtask

  // pin reads pass two sync flops
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #20000;
    err_count++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'h0;
    chk("p2_fsel", 8'h80, port2_function_select_bits);
    chk("p3oe", 8'h00, p3_oe);
    chk("xtal", 8'h07, {p2_7_o, p2_7_oe, xtal_drv_en});
    // the oscillator driver must go before the pin can be read
    crystal_osc_output = 1'h0;
    p2_lvl = 1'h1;
    wr(1, 8'h00);
    settle();
    chk("xtal", 8'h04, {p2_7_ie, p2_7_oe, xtal_drv_en});
    chk("p27in", 8'h01, p2_7_gpio_in);
    wr(0, 8'h80);
    chk("p2_dirs", 8'h80, port2_direction_bits);
    chk("p27", 8'h03, {p2_7_o, p2_7_oe});
    p3_out_bits = 8'hA5;
    wr(2, 8'hFF);
    chk("p3o", 8'hA5, p3_o);
    ser_oe = 6'h2A;
    ser_out = 6'h33;
    wr(3, 8'hFF);
    chk("p3oe", 8'hEA, p3_oe);
    chk("p3o", 8'hB3, p3_o);
    wr(2, 8'h00);
    chk("p3oe", 8'h2A, p3_oe);
    ser_oe = 6'h00;
    p3_lvl = 8'h96;
    settle();
    chk("serin", 8'h16, ser_in);
    ser_oe = 6'h3F;
    wr(6, 8'hE0);
    wr(2, 8'hFF);
    chk("p3oe", 8'h3E, p3_oe);
    chk("p3ie", 8'h00, p3_ie & 8'hC1);
    chk("p3gin", 8'h32, p3_gpio_in);
    timer2_compare_out = 3'h5;
    wr(7, 8'h30);
    wr(5, 8'h1F);
    wr(4, 8'h1F);
    chk("ach", 8'h1F, analog_ch_en);
    chk("p4oe", 8'h07, p4_oe);
    chk("p4o", 8'h05, p4_o & 5'h07);
    chk("p4ie", 8'h07, p4_ie);
    chk("aehi", 8'h30, analog_enable_high);
    chk("p4_dirs", 8'h1F, port4_direction_bits);
    wr(7, 8'h00);
    chk("p4o", 8'h0D, p4_o);
    wr(4, 8'h00);
    p4_lvl = 5'h16;
    settle();
    chk("capa", 8'h06, capture_input_a);
    chk("capb", 8'h02, capture_input_b);
    chk("p4gin", 8'h16, p4_gpio_in);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      #1;
      {serial_a_clock_used, serial_b_clock_used} = i[1:0];
      #1;
      chk("f3w", i[7:0], {serial_b_force_3wire, serial_a_force_3wire});
    end
    // a frozen clock enable must swallow the write
    clk_en = 1'h0;
    wr(3, 8'h00);
    clk_en = 1'h1;
    chk("p3_fsel", 8'hFF, port3_function_select_bits);
    rst = 1'h1;
    @(posedge mclk);
    #1;
    rst = 1'h0;
    chk("p3_fsel", 8'h00, port3_function_select_bits);
    chk("aelo", 8'h00, analog_enable_low);
    chk("p2_fsel", 8'h80, port2_function_select_bits);
    conclude();
  end
endmodule

bind ppm_top ppm_checker chk (.*);
